// ---- shared/spcd_pkg.sv ----
// Purpose: constants and types of the sector protection command decoder
// Assumes: word-addressed command space behind an AHB-Lite slave
// Notes:   command codes compare on the low data byte only
//
// Overview of operation
// - Command data is hex; command addresses count 16-bit words, not bytes.
// - Upper data byte ignored in command cycles except data-carrying ones.
// - Address bits from bit 11 upward ignored in unlock and command cycles.
// - Plain reads in read mode return array contents with no command.
// - Only reset leaves identification mode or a latched status error.
// - Erase suspend only during erase; suspended erase still allows reads.
// - Erase resume only when erase-suspended; program resume likewise.
// - Protection register bits are one-time programmable, 1 to 0 only.
// - Programming both mode lock bits at once aborts to read mode.
// - After an entry command the device stays in the overlay until exit.
// - Exit is 90 then 0 at any address; back to array reading.
// - F0 at any address aborts the overlay and returns to read mode.
// - Lock read: bit 0 low when protected, bits 1 to 15 high.
// - Lock program takes any address inside the sector.
// - Register-style reads are valid for the first word only.
// - Status word: bit0 overall, bit1 volatile, bit2 non-volatile; rest high.
// - Status query: write 60 anywhere, then read at the sector address.
// - Erase all locks: 80 anywhere, then 30 at word 0.
// - In the lock overlay a read at a sector returns its lock in bit 0.
package spcd_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int WORD_AW     = 25;
	localparam int LOW_AW      = 11;
	localparam int SECT_W      = 8;
	localparam int SECT_LSB    = 17;
	localparam int NUM_SECT    = 256;
	localparam int CTL_SEL_BIT = 31;

	// ----------------------------------------------------------------
	// command addresses and codes
	// ----------------------------------------------------------------
	localparam logic [10:0] ADDR_UNLOCK1  = 11'h555;
	localparam logic [10:0] ADDR_UNLOCK2  = 11'h2AA;
	localparam logic [10:0] ADDR_ZERO     = 11'h000;
	localparam logic [7:0]  CMD_UNLOCK1   = 8'hAA;
	localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
	localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;
	localparam logic [7:0]  CMD_NVL_ENTRY = 8'hC0;
	localparam logic [7:0]  CMD_PMR_ENTRY = 8'h40;
	localparam logic [7:0]  CMD_PROGRAM   = 8'hA0;
	localparam logic [7:0]  CMD_ERASE     = 8'h80;
	localparam logic [7:0]  CMD_ERASE_ALL = 8'h30;
	localparam logic [7:0]  CMD_STATUS_Q  = 8'h60;
	localparam logic [7:0]  CMD_EXIT1     = 8'h90;
	localparam logic [7:0]  CMD_EXIT2     = 8'h00;
	localparam logic [7:0]  CMD_RESET     = 8'hF0;
	localparam logic [7:0]  CMD_ERS_SUSP  = 8'hB0;
	localparam logic [7:0]  CMD_ERS_RES   = 8'h30;
	localparam logic [7:0]  CMD_PRG_SUSP  = 8'h51;
	localparam logic [7:0]  CMD_PRG_RES   = 8'h50;
	localparam logic [7:0]  LOCK_PRG_DATA = 8'h00;

	// ----------------------------------------------------------------
	// data words and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] PMR_RESET     = 16'hFFFF;
	localparam int          PMR_PERS_BIT  = 1;
	localparam int          PMR_PWD_BIT   = 2;
	localparam logic [14:0] LOCK_FILL     = 15'h7FFF;
	localparam logic [12:0] PSTAT_FILL    = 13'h1FFF;
	localparam logic [15:0] ID_WORD       = 16'h0A5A; // arbitrary value
	localparam int          STAT_ERR_BIT  = 5;
	localparam int          STAT_RDY_BIT  = 7;
	localparam logic [NUM_SECT-1:0] NVL_RESET = '1;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		M_RD  = 4'b0001,
		M_ID  = 4'b0010,
		M_NVL = 4'b0100,
		M_PMR = 4'b1000
	} spcd_mode_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'b000_0001,
		S_U1   = 7'b000_0010,
		S_U2   = 7'b000_0100,
		S_A0   = 7'b000_1000,
		S_E80  = 7'b001_0000,
		S_Q60  = 7'b010_0000,
		S_X90  = 7'b100_0000
	} spcd_seq_t;

endpackage : spcd_pkg

// ---- tb/spcd_core_model.sv ----
// Purpose: flash core behind the decoder: array words and busy flags
// Assumes: erase and program never finish on their own
// Notes:   array word is a fixed function of the address
module spcd_core_model (
	input wire logic         hclk,
	input wire logic         hresetn,
	input wire logic [24:0]  array_addr,
	output logic [15:0]      array_rdata,
	input wire logic         erase_go,
	input wire logic         program_go,
	input wire logic         erase_suspend_req,
	input wire logic         erase_resume_req,
	input wire logic         program_suspend_req,
	input wire logic         program_resume_req,
	output logic             erase_busy,
	output logic             program_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ers_q, ers_sus_q, prg_q, prg_sus_q;
	// combinational so the word is ready in the same cycle as the address
	assign array_rdata = array_addr[15:0] ^ 16'hA5C3;
	assign erase_busy = ers_q & ~ers_sus_q;
	assign program_busy = prg_q & ~prg_sus_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ers_q <= 1'b0;
			ers_sus_q <= 1'b0;
			prg_q <= 1'b0;
			prg_sus_q <= 1'b0;
		end else begin
			ers_q <= ers_q | erase_go;
			prg_q <= prg_q | program_go;
			if (erase_suspend_req) ers_sus_q <= 1'b1;
			if (erase_resume_req) ers_sus_q <= 1'b0;
			if (program_suspend_req) prg_sus_q <= 1'b1;
			if (program_resume_req) prg_sus_q <= 1'b0;
		end
	end
endmodule : spcd_core_model

// ---- tb/spcd_decoder_properties.sv ----
// Purpose: bus timing and request checks for the command decoder
// Assumes: hready is the decoder's own hreadyout, one slave
// Notes:   sees the top module's ports only
module spcd_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic [24:0] array_addr,
	input wire logic        erase_busy,
	input wire logic        program_busy,
	input wire logic        erase_suspend_req,
	input wire logic        erase_resume_req,
	input wire logic        program_suspend_req,
	input wire logic        program_resume_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	logic susp;
	assign take = hsel && htrans[1] && hready;
	assign susp = erase_suspend_req || program_suspend_req;
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_one_wait: assert property (take |=> s_one_wait)
		else $error("transfer did not take exactly one wait state");
	chk_word_addr: assert property (
		take |=> array_addr == $past(haddr[26:2]))
		else $error("array word address differs from bus address");
	chk_upper_zero: assert property (
		take && !hwrite && !haddr[31] |=> ##1 hrdata[31:16] == 16'h0000)
		else $error("flash read carries upper half data");
	chk_rdata_hold: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data changed outside a transfer");
	chk_esusp_cause: assert property (
		erase_suspend_req |-> $past(erase_busy))
		else $error("erase suspend without running erase");
	chk_eres_cause: assert property (
		erase_resume_req |-> !$past(erase_busy))
		else $error("erase resume while erase running");
	chk_pres_cause: assert property (
		program_resume_req |-> !$past(program_busy))
		else $error("program resume while program running");
	chk_req_pulse: assert property (susp |=> !susp)
		else $error("suspend request longer than one cycle");
	chk_req_single: assert property (
		$onehot0({erase_suspend_req, erase_resume_req,
			program_suspend_req, program_resume_req}))
		else $error("two requests at once");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
endmodule : spcd_checker

bind spcd_decoder spcd_checker spcd_checker_inst (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
	.hresp, .array_addr, .erase_busy, .program_busy,
	.erase_suspend_req, .erase_resume_req, .program_suspend_req,
	.program_resume_req);

// ---- tb/tb_sector_protection_command_decoder.sv ----
// Purpose: command sequences driven over the bus with expected words
// Assumes: one wait state per transfer, status register at bit 31
// Notes:   suspend traffic runs last since busy reads return status
module tb_sector_protection_command_decoder;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [24:0] DC = 25'h0AB_CDEF;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        erase_go, program_go, erase_busy, program_busy;
	logic        status_error_bit;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [24:0] array_addr;
	logic [15:0] array_rdata;
	logic [3:0]  rq;
	int          np [4];
	int          num_errors, checked;

	spcd_decoder spcd_decoder_inst (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .array_addr, .array_rdata,
		.erase_busy, .program_busy, .status_error_bit,
		.erase_suspend_req(rq[0]), .erase_resume_req(rq[1]),
		.program_suspend_req(rq[2]), .program_resume_req(rq[3]));
	spcd_core_model spcd_core_model_inst (.hclk, .hresetn, .array_addr,
		.array_rdata, .erase_go, .program_go,
		.erase_suspend_req(rq[0]), .erase_resume_req(rq[1]),
		.program_suspend_req(rq[2]), .program_resume_req(rq[3]),
		.erase_busy, .program_busy);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		for (int i = 0; i < 4; i++) np[i] += (rq[i] === 1'b1);
	end

	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask : cmp

	// a bounded wait: a stuck slave ends the run as a mismatch
	task automatic xfer(input logic w, input logic [31:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do begin @(posedge hclk); n++; end
		while (hreadyout !== 1'b1 && n < 20);
		htrans <= 2'b00;
		hwdata <= d;
		do begin @(posedge hclk); n++; end
		while (hreadyout !== 1'b1 && n < 20);
		r = hrdata;
		if (n >= 20) begin
			num_errors++;
			finish_test();
		end
	endtask : xfer

	task automatic wr(input logic [24:0] wa, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, {5'd0, wa, 2'b00}, d, r);
	endtask : wr

	task automatic rd(input logic [24:0] wa, input logic [15:0] e);
		logic [31:0] r;
		xfer(1'b0, {5'd0, wa, 2'b00}, 32'h0000_0000, r);
		cmp(r, {16'h0000, e});
	endtask : rd

	task automatic ra(input logic [24:0] wa);
		rd(wa, wa[15:0] ^ 16'hA5C3);
	endtask : ra

	// high address bits and upper data byte carry junk on purpose
	task automatic ent(input logic [7:0] code);
		wr({14'h2A5C, 11'h555}, 32'h5A5A_12AA);
		wr({14'h15A3, 11'h2AA}, 32'hA5A5_EE55);
		wr({14'h0F0F, 11'h555}, {24'hC3C3_77, code});
	endtask : ent

	initial begin
		logic [31:0] r;
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		erase_go = 1'b0;
		program_go = 1'b0;
		status_error_bit = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, 32'h8000_0000, 32'h0000_0000, r);
		cmp(r, 32'h0000_0081);
		ra(25'h00_1234);
		ent(spcd_pkg::CMD_NVL_ENTRY);
		rd({8'd5, 17'h0_0000}, 16'hFFFF);
		wr(DC, 32'h7E00_00A0);
		wr({8'd5, 17'h1_2345}, 32'h0000_0000);
		rd({8'd5, 17'h0_0777}, 16'hFFFE);
		rd({8'd6, 17'h0_0000}, 16'hFFFF);
		wr(DC, 32'h0000_0060);
		rd({8'd5, 17'h0_0009}, 16'hFFFA);
		rd({8'd5, 17'h0_0009}, 16'hFFFE);
		wr(DC, 32'h0000_0080);
		wr(25'h1, 32'h0000_0030);
		rd({8'd5, 17'h0_0000}, 16'hFFFE);
		wr(DC, 32'h0000_0080);
		wr(25'h0, 32'h0000_0030);
		rd({8'd5, 17'h0_0000}, 16'hFFFF);
		wr(DC, 32'h0000_0090);
		wr(DC, 32'h0000_0011);
		rd({8'd5, 17'h0_0000}, 16'hFFFF);
		wr(DC, 32'h0000_0090);
		wr(DC, 32'h0000_0000);
		ra({8'd5, 17'h0_0000});
		ent(spcd_pkg::CMD_NVL_ENTRY);
		wr(DC, 32'h0000_00F0);
		ra(25'h00_0042);
		wr(25'h555, 32'h0000_00AA);
		wr(25'h2AA, 32'h0000_0055);
		wr(25'h556, 32'h0000_00C0);
		ra(25'h00_0043);
		ent(spcd_pkg::CMD_ID_ENTRY);
		rd(25'h0, spcd_pkg::ID_WORD);
		wr(DC, 32'h0000_0090);
		wr(DC, 32'h0000_0000);
		rd(25'h0, spcd_pkg::ID_WORD);
		wr(DC, 32'h0000_00F0);
		ra(25'h00_0044);
		ent(spcd_pkg::CMD_PMR_ENTRY);
		rd(25'h0, 16'hFFFF);
		wr(DC, 32'h0000_00A0);
		wr(DC, 32'h0000_FFF9);
		ra(25'h00_0045);
		ent(spcd_pkg::CMD_PMR_ENTRY);
		rd(25'h0, 16'hFFFF);
		wr(DC, 32'h0000_00A0);
		wr(DC, 32'h0000_FFFD);
		rd(25'h0, 16'hFFFD);
		wr(DC, 32'h0000_00A0);
		wr(DC, 32'h0000_FFFF);
		rd(25'h0, 16'hFFFD);
		wr(DC, 32'h0000_00F0);
		// suspend and resume with nothing running are ignored
		wr(DC, 32'h0000_00B0);
		wr(DC, 32'h0000_0050);
		erase_go <= 1'b1;
		@(posedge hclk);
		erase_go <= 1'b0;
		wr(DC, 32'h0000_00B0);
		wr(DC, 32'h0000_0030);
		wr(DC, 32'h0000_00B0);
		program_go <= 1'b1;
		@(posedge hclk);
		program_go <= 1'b0;
		wr(DC, 32'h0000_0051);
		wr(DC, 32'h0000_0030);
		wr(DC, 32'h0000_0050);
		repeat (2) @(posedge hclk);
		cmp(np[0], 32'd2);
		cmp(np[1], 32'd1);
		cmp(np[2], 32'd1);
		cmp(np[3], 32'd1);
		// busy reads give status; a latched error leaves only reset
		rd(DC, 16'h0000);
		status_error_bit <= 1'b1;
		@(posedge hclk);
		status_error_bit <= 1'b0;
		rd(DC, 16'h0020);
		wr(25'h555, 32'h0000_00AA);
		xfer(1'b0, 32'h8000_0000, 32'h0000_0000, r);
		cmp(r, 32'h0000_00D1);
		wr(DC, 32'h0000_00F0);
		xfer(1'b0, 32'h8000_0000, 32'h0000_0000, r);
		cmp(r, 32'h0000_0091);
		finish_test();
	end
endmodule : tb_sector_protection_command_decoder

// ---- verilog/spcd_decoder.sv ----
// Purpose: command-sequence decoder for non-volatile sector protection
// Assumes: single-word AHB-Lite transfers; array data valid in the
//          same cycle that array_addr changes
// Notes:   every transfer holds one wait state; haddr bit 31 selects
//          the decoder's own status register instead of the flash space
module spcd_decoder (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	output logic [24:0]      array_addr,
	input  wire logic [15:0] array_rdata,
	input  wire logic        erase_busy,
	input  wire logic        program_busy,
	input  wire logic        status_error_bit,
	output logic             erase_suspend_req,
	output logic             erase_resume_req,
	output logic             program_suspend_req,
	output logic             program_resume_req
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spcd_pkg::spcd_mode_t mode;
		spcd_pkg::spcd_seq_t  seq;
		logic [15:0]          pmr;
		logic                 esusp;
		logic                 psusp;
		logic                 err;
		logic                 pend;
		logic                 pwrite;
		logic                 pctl;
		logic [24:0]          paddr;
		logic                 hready;
		logic                 hresp;
		logic [31:0]          hrdata;
		logic [24:0]          aaddr;
		logic                 ers_susp;
		logic                 ers_res;
		logic                 prg_susp;
		logic                 prg_res;
	} spcd_state_t;

	spcd_state_t s_q;
	spcd_state_t s_d;

	logic        nv_prog;
	logic        nv_erase;
	logic        nv_unlocked;
	logic        take;
	logic        busy;
	logic [7:0]  wd;
	logic [10:0] la;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// upper data byte is a don't-care for command codes
	function automatic logic is_cmd(input logic [31:0] d,
	                                input logic [7:0]  code);
		is_cmd = (d[7:0] == code);
	endfunction : is_cmd

	// only the bits below 11 matter in unlock and command cycles
	function automatic logic [10:0] low_addr(input logic [24:0] w);
		low_addr = w[spcd_pkg::LOW_AW-1:0];
	endfunction : low_addr

	function automatic logic [7:0] sector_of(input logic [24:0] w);
		sector_of = w[spcd_pkg::SECT_LSB +: spcd_pkg::SECT_W];
	endfunction : sector_of

	function automatic logic [15:0] status_word(input logic rdy,
	                                            input logic err);
		logic [15:0] v;
		v = 16'h0000;
		v[spcd_pkg::STAT_RDY_BIT] = rdy;
		v[spcd_pkg::STAT_ERR_BIT] = err;
		status_word = v;
	endfunction : status_word

	// ----------------------------------------------------------------
	// lock bit storage
	// ----------------------------------------------------------------
	spcd_lock_store u_store (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.sel_idx   (sector_of(s_q.paddr)),
		.prog_lock (nv_prog),
		.erase_all (nv_erase),
		.unlocked  (nv_unlocked)
	);

	// ----------------------------------------------------------------
	// bus capture and decode
	// ----------------------------------------------------------------
	// a word address is the byte address over four
	assign take = hsel && htrans[1] && hready && !s_q.pend;
	assign busy = (erase_busy && !s_q.esusp) ||
	              (program_busy && !s_q.psusp);
	assign wd   = hwdata[7:0];
	assign la   = low_addr(s_q.paddr);

	always_comb begin
		s_d          = s_q;
		s_d.ers_susp = 1'b0;
		s_d.ers_res  = 1'b0;
		s_d.prg_susp = 1'b0;
		s_d.prg_res  = 1'b0;
		nv_prog      = 1'b0;
		nv_erase     = 1'b0;

		// hardware status error wins over a reset in the same cycle
		if (status_error_bit && busy && s_q.mode == spcd_pkg::M_RD) begin
			s_d.err = 1'b1;
		end

		if (s_q.pend) begin
			s_d.pend   = 1'b0;
			s_d.hready = 1'b1;
			s_d.hrdata = 32'h0000_0000;

			// ------------------------------------------------
			// decoder status register
			// ------------------------------------------------
			if (s_q.pctl) begin
				if (!s_q.pwrite) begin
					s_d.hrdata = {18'h0_0000, s_q.seq, s_q.err,
					              s_q.psusp, s_q.esusp, s_q.mode};
				end
			end

			// ------------------------------------------------
			// command writes
			// ------------------------------------------------
			else if (s_q.pwrite) begin
				if (is_cmd(hwdata, spcd_pkg::CMD_RESET)) begin
					s_d.mode = spcd_pkg::M_RD;
					s_d.seq  = spcd_pkg::S_IDLE;
					if (!status_error_bit) begin
						s_d.err = 1'b0;
					end
				end else if (s_q.seq == spcd_pkg::S_X90) begin
					s_d.seq = spcd_pkg::S_IDLE;
					if (is_cmd(hwdata, spcd_pkg::CMD_EXIT2)) begin
						s_d.mode = spcd_pkg::M_RD;
					end
				end else begin
					case (s_q.mode)
					spcd_pkg::M_RD: begin
						// a latched error leaves only reset to act
						if (!s_q.err) begin
							case (s_q.seq)
							spcd_pkg::S_U1: begin
								if (is_cmd(hwdata, spcd_pkg::CMD_UNLOCK2) &&
								    la == spcd_pkg::ADDR_UNLOCK2) begin
									s_d.seq = spcd_pkg::S_U2;
								end else begin
									s_d.seq = spcd_pkg::S_IDLE;
								end
							end
							spcd_pkg::S_U2: begin
								s_d.seq = spcd_pkg::S_IDLE;
								if (la == spcd_pkg::ADDR_UNLOCK1) begin
									if (wd == spcd_pkg::CMD_ID_ENTRY &&
									    (!erase_busy || s_q.esusp)) begin
										s_d.mode = spcd_pkg::M_ID;
									end else if (!busy && !s_q.esusp &&
									    wd == spcd_pkg::CMD_NVL_ENTRY) begin
										s_d.mode = spcd_pkg::M_NVL;
									end else if (!busy && !s_q.esusp &&
									    wd == spcd_pkg::CMD_PMR_ENTRY) begin
										s_d.mode = spcd_pkg::M_PMR;
									end
								end
							end
							default: begin
								s_d.seq = spcd_pkg::S_IDLE;
								if (is_cmd(hwdata, spcd_pkg::CMD_UNLOCK1) &&
								    la == spcd_pkg::ADDR_UNLOCK1) begin
									s_d.seq = spcd_pkg::S_U1;
								end else if (wd == spcd_pkg::CMD_ERS_SUSP) begin
									if (erase_busy && !s_q.esusp) begin
										s_d.esusp    = 1'b1;
										s_d.ers_susp = 1'b1;
									end
								end else if (wd == spcd_pkg::CMD_ERS_RES) begin
									if (s_q.esusp && !s_q.psusp) begin
										s_d.esusp   = 1'b0;
										s_d.ers_res = 1'b1;
									end
								end else if (wd == spcd_pkg::CMD_PRG_SUSP) begin
									if (program_busy && !s_q.psusp) begin
										s_d.psusp    = 1'b1;
										s_d.prg_susp = 1'b1;
									end
								end else if (wd == spcd_pkg::CMD_PRG_RES) begin
									if (s_q.psusp) begin
										s_d.psusp   = 1'b0;
										s_d.prg_res = 1'b1;
									end
								end
							end
							endcase
						end
					end
					spcd_pkg::M_NVL: begin
						case (s_q.seq)
						spcd_pkg::S_A0: begin
							s_d.seq = spcd_pkg::S_IDLE;
							if (wd == spcd_pkg::LOCK_PRG_DATA) begin
								nv_prog = 1'b1;
							end
						end
						spcd_pkg::S_E80: begin
							s_d.seq = spcd_pkg::S_IDLE;
							if (wd == spcd_pkg::CMD_ERASE_ALL &&
							    la == spcd_pkg::ADDR_ZERO) begin
								nv_erase = 1'b1;
							end
						end
						default: begin
							// anything unknown keeps the overlay
							s_d.seq = spcd_pkg::S_IDLE;
							if (wd == spcd_pkg::CMD_PROGRAM) begin
								s_d.seq = spcd_pkg::S_A0;
							end else if (wd == spcd_pkg::CMD_ERASE) begin
								s_d.seq = spcd_pkg::S_E80;
							end else if (wd == spcd_pkg::CMD_STATUS_Q) begin
								s_d.seq = spcd_pkg::S_Q60;
							end else if (wd == spcd_pkg::CMD_EXIT1) begin
								s_d.seq = spcd_pkg::S_X90;
							end
						end
						endcase
					end
					spcd_pkg::M_PMR: begin
						if (s_q.seq == spcd_pkg::S_A0) begin
							s_d.seq = spcd_pkg::S_IDLE;
							// both mode locks going 1 to 0 together
							if (s_q.pmr[spcd_pkg::PMR_PERS_BIT] &&
							    s_q.pmr[spcd_pkg::PMR_PWD_BIT] &&
							    !hwdata[spcd_pkg::PMR_PERS_BIT] &&
							    !hwdata[spcd_pkg::PMR_PWD_BIT]) begin
								s_d.mode = spcd_pkg::M_RD;
							end else begin
								// full 16 bits carry program data
								s_d.pmr = s_q.pmr & hwdata[15:0];
							end
						end else if (wd == spcd_pkg::CMD_PROGRAM) begin
							s_d.seq = spcd_pkg::S_A0;
						end else if (wd == spcd_pkg::CMD_EXIT1) begin
							s_d.seq = spcd_pkg::S_X90;
						end else begin
							s_d.seq = spcd_pkg::S_IDLE;
						end
					end
					default: begin
						// identification mode answers only to reset
						s_d.seq = spcd_pkg::S_IDLE;
					end
					endcase
				end
			end

			// ------------------------------------------------
			// reads
			// ------------------------------------------------
			else begin
				case (s_q.mode)
				spcd_pkg::M_RD: begin
					if (s_q.err || busy) begin
						s_d.hrdata[15:0] = status_word(!busy,
						    s_q.err || status_error_bit);
					end else begin
						s_d.hrdata[15:0] = array_rdata;
					end
				end
				spcd_pkg::M_ID: begin
					s_d.hrdata[15:0] = spcd_pkg::ID_WORD;
				end
				spcd_pkg::M_NVL: begin
					if (s_q.seq == spcd_pkg::S_Q60) begin
						// volatile locks are not held here: unprotected
						s_d.hrdata[15:0] = {spcd_pkg::PSTAT_FILL,
						    nv_unlocked, 1'b1, nv_unlocked};
						// the query answers once, later reads see locks
						s_d.seq = spcd_pkg::S_IDLE;
					end else begin
						s_d.hrdata[15:0] = {spcd_pkg::LOCK_FILL,
						    nv_unlocked};
					end
				end
				default: begin
					s_d.hrdata[15:0] = s_q.pmr;
				end
				endcase
			end
		end else if (take) begin
			s_d.pend   = 1'b1;
			s_d.hready = 1'b0;
			s_d.pwrite = hwrite;
			s_d.pctl   = haddr[spcd_pkg::CTL_SEL_BIT];
			s_d.paddr  = haddr[spcd_pkg::WORD_AW+1:2];
			s_d.aaddr  = haddr[spcd_pkg::WORD_AW+1:2];
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.mode     <= spcd_pkg::M_RD;
			s_q.seq      <= spcd_pkg::S_IDLE;
			s_q.pmr      <= spcd_pkg::PMR_RESET;
			s_q.esusp    <= 1'b0;
			s_q.psusp    <= 1'b0;
			s_q.err      <= 1'b0;
			s_q.pend     <= 1'b0;
			s_q.pwrite   <= 1'b0;
			s_q.pctl     <= 1'b0;
			s_q.paddr    <= 25'h000_0000;
			s_q.hready   <= 1'b1;
			s_q.hresp    <= 1'b0;
			s_q.hrdata   <= 32'h0000_0000;
			s_q.aaddr    <= 25'h000_0000;
			s_q.ers_susp <= 1'b0;
			s_q.ers_res  <= 1'b0;
			s_q.prg_susp <= 1'b0;
			s_q.prg_res  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout           = s_q.hready;
	assign hrdata              = s_q.hrdata;
	assign hresp               = s_q.hresp;
	assign array_addr          = s_q.aaddr;
	assign erase_suspend_req   = s_q.ers_susp;
	assign erase_resume_req    = s_q.ers_res;
	assign program_suspend_req = s_q.prg_susp;
	assign program_resume_req  = s_q.prg_res;

	// hsize is accepted but unused: only whole words are expected
	logic unused_size;
	assign unused_size = ^hsize;

endmodule : spcd_decoder

// ---- verilog/spcd_lock_store.sv ----
// Purpose: per-sector non-volatile lock bits, one flop per sector
// Assumes: program and erase strobes are single-cycle
// Notes:   a set bit means unprotected, matching the read polarity
module spcd_lock_store (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic [spcd_pkg::SECT_W-1:0] sel_idx,
	input  wire logic                      prog_lock,
	input  wire logic                      erase_all,
	output logic                           unlocked
);

	typedef struct packed {
		logic [spcd_pkg::NUM_SECT-1:0] bits;
	} spcd_store_t;

	spcd_store_t s_q;
	spcd_store_t s_d;

	always_comb begin
		s_d = s_q;
		// erase and program never coincide; erase checked first anyway
		if (erase_all) begin
			s_d.bits = '1;
		end else if (prog_lock) begin
			s_d.bits[sel_idx] = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.bits <= spcd_pkg::NVL_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign unlocked = s_q.bits[sel_idx];

endmodule : spcd_lock_store
